/* core/ufbsr_top.v */
// Local design decisions: strobed register access and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "ufbsr_consts.vh"

// ============================================================
// Load word buffer.
module ufbsr_fifo #(
    parameter WIDTH = 4,
    parameter DEPTH = 16,
    parameter AW = 4
) (
    input wire CLK_I,
    input wire ARST_N_I,
    input wire [WIDTH-1:0] in_data_i,
    input wire in_valid_i,
    output reg in_ready_o,
    output wire [WIDTH-1:0] out_data_o,
    output reg out_valid_o,
    input wire out_ready_i,
    output reg [AW:0] count_o
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_ptr_reg;
    reg [AW-1:0] rd_ptr_reg;
    wire push = in_valid_i & in_ready_o;
    wire pop = out_valid_o & out_ready_i;
    reg [AW:0] count_next;

    assign out_data_o = mem[rd_ptr_reg];

    always @* begin
        count_next = count_o;
        if (push && !pop) begin
            count_next = count_o + 1'b1;
        end else if (pop && !push) begin
            count_next = count_o - 1'b1;
        end
    end

    always @(posedge CLK_I) begin
        if (push) begin
            mem[wr_ptr_reg] <= in_data_i;
        end
    end

    always @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            wr_ptr_reg <= {AW{1'b0}};
            rd_ptr_reg <= {AW{1'b0}};
            count_o <= {(AW+1){1'b0}};
            in_ready_o <= 1'b1;
            out_valid_o <= 1'b0;
        end else begin
            if (push) begin
                wr_ptr_reg <= (wr_ptr_reg == DEPTH - 1) ? {AW{1'b0}} : wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= (rd_ptr_reg == DEPTH - 1) ? {AW{1'b0}} : rd_ptr_reg + 1'b1;
            end
            count_o <= count_next;
            // Full and empty come from the next count so they never lag a push or pop.
            in_ready_o <= (count_next != DEPTH);
            out_valid_o <= (count_next != {(AW+1){1'b0}});
        end
    end
endmodule

// ============================================================
// Summary of operation
// - Load select high means shift mode; first stage fed by serial set/clear.
// - In shift mode each taken clock edge moves stages one place towards the last.
// - Load select low copies parallel bit n into stage n, or buffered word bit n when feed is set and the buffer holds a word; serial inputs ignored.
// - Set high with clear-n high gives 1; both low gives 0 in first stage.
// - Set high with clear-n low toggles the first stage.
// - Set low with clear-n high keeps first stage while others shift.
// - Clear low forces all stages to 0 at once, without any clock edge.
// - Extra output is always the inverse of the last stage.
// - Mode, serial and parallel inputs are sampled only at the clock edge.
module ufbsr_top #(
    parameter FIFO_DEPTH = `UFBSR_FIFO_DEPTH,
    parameter FIFO_AW = 4
) (
    input wire CLK_I,
    input wire ARST_N_I,
    input wire SHIFT_CLOCK_I,
    input wire ASYNC_CLEAR_N_I,
    input wire LOAD_SELECT_N_I,
    input wire SERIAL_SET_I,
    input wire SERIAL_CLEAR_N_I,
    input wire [3:0] LOAD_WORD_IN_I,
    output reg [3:0] STAGE_OUT_O,
    output reg LAST_STAGE_OUT_N_O,
    output wire LOAD_FIFO_READY_O,
    input wire [`UFBSR_ADDR_W-1:0] ADDR_I,
    input wire [31:0] WDATA_I,
    input wire WR_I,
    input wire RD_I,
    output reg [31:0] RDATA_O
);
    // ============================================================
    // Pin synchronisers, three stages each.
    wire [`UFBSR_SYNC_BITS-1:0] pin_raw = {LOAD_WORD_IN_I, SERIAL_CLEAR_N_I, SERIAL_SET_I,
                                           LOAD_SELECT_N_I, SHIFT_CLOCK_I};
    reg [`UFBSR_SYNC_BITS-1:0] sync1_reg;
    reg [`UFBSR_SYNC_BITS-1:0] sync2_reg;
    reg [`UFBSR_SYNC_BITS-1:0] sync3_reg;
    reg [`UFBSR_SYNC_BITS-1:0] pin_reg;

    genvar gi;
    generate
        for (gi = 0; gi < `UFBSR_SYNC_BITS; gi = gi + 1) begin : g_sync
            always @(posedge CLK_I or negedge ARST_N_I) begin
                if (!ARST_N_I) begin
                    sync1_reg[gi] <= 1'b0;
                    sync2_reg[gi] <= 1'b0;
                    sync3_reg[gi] <= 1'b0;
                    pin_reg[gi] <= 1'b0;
                end else begin
                    sync1_reg[gi] <= pin_raw[gi];
                    sync2_reg[gi] <= sync1_reg[gi];
                    sync3_reg[gi] <= sync2_reg[gi];
                    // A change counts only once two settled stages agree.
                    if (sync2_reg[gi] == sync3_reg[gi]) begin
                        pin_reg[gi] <= sync3_reg[gi];
                    end
                end
            end
        end
    endgenerate

    // Filtered clock rising edge; data is taken from the same settled stage.
    wire clk_edge = sync2_reg[0] & sync3_reg[0] & ~pin_reg[0];
    wire load_sel_n = sync3_reg[1];
    wire ser_set = sync3_reg[2];
    wire ser_clr_n = sync3_reg[3];
    wire [3:0] pin_word = sync3_reg[7:4];

    // ============================================================
    // Control registers and load word buffer.
    reg feed_reg;
    reg [`UFBSR_EDGE_COUNT_W-1:0] edge_count_reg;
    wire [3:0] fifo_word;
    wire fifo_valid;
    wire [FIFO_AW:0] fifo_count;
    wire fifo_push = WR_I && (ADDR_I == `UFBSR_OFF_LOAD_PUSH);
    // The buffer drains only on parallel loads, so writes back up until loads take them.
    wire fifo_pop = clk_edge & ~load_sel_n & feed_reg;

    ufbsr_fifo #(
        .WIDTH(4),
        .DEPTH(FIFO_DEPTH),
        .AW(FIFO_AW)
    ) u_fifo (
        .CLK_I(CLK_I),
        .ARST_N_I(ARST_N_I),
        .in_data_i(WDATA_I[3:0]),
        .in_valid_i(fifo_push),
        .in_ready_o(LOAD_FIFO_READY_O),
        .out_data_o(fifo_word),
        .out_valid_o(fifo_valid),
        .out_ready_i(fifo_pop),
        .count_o(fifo_count)
    );

    // ============================================================
    // Shift register stages.
    wire clear_n = ARST_N_I & ASYNC_CLEAR_N_I;
    wire [3:0] load_word = (feed_reg && fifo_valid) ? fifo_word : pin_word;
    reg [3:0] stage_next;
    reg first_next;

    always @* begin
        case ({ser_set, ser_clr_n})
            2'b11: first_next = 1'b1;
            2'b00: first_next = 1'b0;
            2'b10: first_next = ~STAGE_OUT_O[0];
            2'b01: first_next = STAGE_OUT_O[0];
            default: first_next = STAGE_OUT_O[0];
        endcase
        if (!load_sel_n) begin
            stage_next = load_word;
        end else begin
            stage_next = {STAGE_OUT_O[2:0], first_next};
        end
    end

    always @(posedge CLK_I or negedge clear_n) begin
        if (!clear_n) begin
            STAGE_OUT_O <= `UFBSR_STAGE_RESET;
            LAST_STAGE_OUT_N_O <= `UFBSR_LAST_N_RESET;
        end else if (clk_edge) begin
            STAGE_OUT_O <= stage_next;
            LAST_STAGE_OUT_N_O <= ~stage_next[3];
        end
    end

    // ============================================================
    // Register port.
    always @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            feed_reg <= `UFBSR_CTRL_RESET;
            edge_count_reg <= {`UFBSR_EDGE_COUNT_W{1'b0}};
            RDATA_O <= 32'h00000000;
        end else begin
            if (WR_I && ADDR_I == `UFBSR_OFF_CTRL) begin
                feed_reg <= WDATA_I[`UFBSR_CTRL_FEED_BIT];
            end
            if (WR_I && ADDR_I == `UFBSR_OFF_EDGE_COUNT) begin
                edge_count_reg <= {`UFBSR_EDGE_COUNT_W{1'b0}};
            end else if (clk_edge) begin
                edge_count_reg <= edge_count_reg + 1'b1;
            end
            RDATA_O <= 32'h00000000;
            if (RD_I) begin
                case (ADDR_I)
                    `UFBSR_OFF_CTRL: RDATA_O[`UFBSR_CTRL_FEED_BIT] <= feed_reg;
                    `UFBSR_OFF_STATUS: begin
                        RDATA_O[`UFBSR_STATUS_STAGE_LSB+3:`UFBSR_STATUS_STAGE_LSB] <= STAGE_OUT_O;
                        RDATA_O[`UFBSR_STATUS_LAST_N_BIT] <= LAST_STAGE_OUT_N_O;
                        RDATA_O[`UFBSR_STATUS_EMPTY_BIT] <= ~fifo_valid;
                        RDATA_O[`UFBSR_STATUS_FULL_BIT] <= ~LOAD_FIFO_READY_O;
                        RDATA_O[`UFBSR_STATUS_CLOCK_BIT] <= pin_reg[0];
                        RDATA_O[`UFBSR_STATUS_COUNT_LSB+FIFO_AW:`UFBSR_STATUS_COUNT_LSB] <= fifo_count;
                    end
                    `UFBSR_OFF_EDGE_COUNT: RDATA_O[`UFBSR_EDGE_COUNT_W-1:0] <= edge_count_reg;
                    default: RDATA_O <= 32'h00000000;
                endcase
            end
        end
    end
endmodule
`default_nettype wire

/* core/ufbsr_consts.vh */
`ifndef UFBSR_CONSTS_VH
`define UFBSR_CONSTS_VH

// ============================================================
// Register map, byte addresses on the register port.
`define UFBSR_ADDR_W 8
`define UFBSR_OFF_CTRL 8'h00
`define UFBSR_OFF_STATUS 8'h04
`define UFBSR_OFF_LOAD_PUSH 8'h08
`define UFBSR_OFF_EDGE_COUNT 8'h0C

// ============================================================
// Field positions.
`define UFBSR_CTRL_FEED_BIT 0
`define UFBSR_STATUS_STAGE_LSB 0
`define UFBSR_STATUS_LAST_N_BIT 4
`define UFBSR_STATUS_EMPTY_BIT 5
`define UFBSR_STATUS_FULL_BIT 6
`define UFBSR_STATUS_CLOCK_BIT 7
`define UFBSR_STATUS_COUNT_LSB 8

// ============================================================
// Reset values and sizes.
`define UFBSR_STAGES 4
`define UFBSR_CTRL_RESET 1'b0
`define UFBSR_STAGE_RESET 4'h0
`define UFBSR_LAST_N_RESET 1'b1
`define UFBSR_FIFO_DEPTH 16
`define UFBSR_EDGE_COUNT_W 16
`define UFBSR_SYNC_BITS 8

`endif

/* verif/ufbsr_checker.sv */
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Port checker.
module ufbsr_checker (
    input wire logic CLK_I,
    input wire logic ARST_N_I,
    input wire logic SHIFT_CLOCK_I,
    input wire logic ASYNC_CLEAR_N_I,
    input wire logic LOAD_SELECT_N_I,
    input wire logic SERIAL_SET_I,
    input wire logic SERIAL_CLEAR_N_I,
    input wire logic [3:0] LOAD_WORD_IN_I,
    input wire logic [3:0] STAGE_OUT_O,
    input wire logic LAST_STAGE_OUT_N_O,
    input wire logic [7:0] ADDR_I,
    input wire logic [31:0] WDATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    input wire logic [31:0] RDATA_O
);
    // Loads from the buffer do not follow the pins, so the load check stands aside then.
    logic feed_reg;
    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            feed_reg <= 1'b0;
        end else if (WR_I && ADDR_I == 8'h00) begin
            feed_reg <= WDATA_I[0];
        end
    end
    default clocking @(posedge CLK_I); endclocking
    default disable iff (!ARST_N_I);
    a_last_inverse: assert property (LAST_STAGE_OUT_N_O == !STAGE_OUT_O[3]) else $error("last_n");
    a_clear_zero: assert property (!ASYNC_CLEAR_N_I |-> STAGE_OUT_O == 4'h0) else $error("clear");
    a_hold_quiet: assert property ((!SHIFT_CLOCK_I && ASYNC_CLEAR_N_I)[*6] |-> $stable(STAGE_OUT_O))
        else $error("hold");
    a_shift_move: assert property ($changed(STAGE_OUT_O) && ASYNC_CLEAR_N_I && $past(ASYNC_CLEAR_N_I)
        && LOAD_SELECT_N_I |-> STAGE_OUT_O[3:1] == $past(STAGE_OUT_O[2:0])) else $error("shift");
    a_first_stage: assert property ($changed(STAGE_OUT_O) && ASYNC_CLEAR_N_I && $past(ASYNC_CLEAR_N_I)
        && LOAD_SELECT_N_I |-> STAGE_OUT_O[0] == (SERIAL_SET_I && !$past(STAGE_OUT_O[0])
        || SERIAL_CLEAR_N_I && $past(STAGE_OUT_O[0]))) else $error("first");
    a_load_copy: assert property ($changed(STAGE_OUT_O) && ASYNC_CLEAR_N_I && $past(ASYNC_CLEAR_N_I)
        && !LOAD_SELECT_N_I && !feed_reg |-> STAGE_OUT_O == LOAD_WORD_IN_I) else $error("load");
    a_read_idle: assert property (!$past(RD_I) |-> RDATA_O == 32'h0) else $error("rdata");
    a_status_mirror: assert property ($past(RD_I && ADDR_I == 8'h04)
        |-> RDATA_O[4:0] == {!$past(STAGE_OUT_O[3]), $past(STAGE_OUT_O)}) else $error("status");
endmodule
bind ufbsr_top ufbsr_checker ufbsr_checker_inst (.*);
`default_nettype wire

/* verif/ufbsr_far_end.sv */
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Surrounding logic: one shift clock pulse per request.
module ufbsr_far_end (
    input wire logic clk_i,
    input wire logic go_i,
    output logic sck_o,
    output logic busy_o
);
    logic [3:0] cnt_reg = 4'h0;
    always @(posedge clk_i) begin
        cnt_reg <= go_i ? 4'hE : cnt_reg - {3'h0, cnt_reg != 4'h0};
    end
    // Low 5, high 7, low 2: data set at the request stays put well past the rise.
    assign sck_o = cnt_reg > 4'h2 && cnt_reg < 4'hA;
    assign busy_o = cnt_reg != 4'h0;
endmodule
`default_nettype wire

/* verif/ufbsr_top_bench.sv */
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Self-checking bench.
module ufbsr_top_bench;
    logic clk = 0, rst_n = 0, clr_n = 1, pe_n = 1, j = 0, kn = 0, wr = 0, rd = 0, go = 0, qn, rdy, sck, busy;
    logic [3:0] word = 4'h0, q;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, v;
    int fails = 0, check_count = 0;
    // Rows: load select, set, clear, word, then the stages expected.
    logic [10:0] rows [9] = '{11'h0AA, 11'h705, 11'h40A, 11'h605, 11'h50B, 11'h333, 11'h011, 11'h703, 11'h406};
    ufbsr_top ufbsr_top_inst (.CLK_I(clk), .ARST_N_I(rst_n), .SHIFT_CLOCK_I(sck), .ASYNC_CLEAR_N_I(clr_n),
        .LOAD_SELECT_N_I(pe_n), .SERIAL_SET_I(j), .SERIAL_CLEAR_N_I(kn), .LOAD_WORD_IN_I(word), .STAGE_OUT_O(q),
        .LAST_STAGE_OUT_N_O(qn), .LOAD_FIFO_READY_O(rdy), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd),
        .RDATA_O(rdata));
    ufbsr_far_end ufbsr_far_end_inst (.clk_i(clk), .go_i(go), .sck_o(sck), .busy_o(busy));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic step(input logic [6:0] s);
        @(posedge clk);
        {pe_n, j, kn, word} <= s;
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        @(posedge clk);
        while (busy) @(posedge clk);
        #1;
    endtask
    task automatic wreg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        {addr, wdata, wr} <= {a, d, 1'b1};
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask
    task automatic rreg(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        {addr, rd} <= {a, 1'b1};
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        forever #2.5 clk = ~clk;
    end
    initial begin
        #50000;
        fails++;
        end_sim();
    end
    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        foreach (rows[i]) begin
            step(rows[i][10:4]);
            chk(32'({qn, q}), 32'({~rows[i][3], rows[i][3:0]}));
        end
        @(posedge clk);
        {pe_n, j, word} <= {1'b0, 1'b1, 4'h9};
        repeat (8) @(posedge clk);
        #1 chk(32'(q), 32'h6);
        @(posedge clk);
        clr_n <= 1'b0;
        #1 chk(32'({qn, q}), 32'h10);
        @(posedge clk);
        clr_n <= 1'b1;
        rreg(8'h04, v);
        chk(v, 32'h30);
        rreg(8'h40, v);
        chk(v, 32'h0);
        wreg(8'h00, 32'h1);
        for (int i = 0; i < 16; i++) wreg(8'h08, 32'(i));
        chk(32'(rdy), 32'h0);
        wreg(8'h08, 32'h9);
        rreg(8'h04, v);
        chk(32'(v[12:5]), 32'h82);
        for (int i = 0; i < 16; i++) begin
            step(7'h0C);
            chk(32'(q), 32'(i));
        end
        step(7'h0C);
        chk(32'(q), 32'hC);
        step({3'b000, 1'b0, q[3:1]});
        chk(32'(q), 32'h6);
        rreg(8'h04, v);
        chk(32'(v[12:5]), 32'h01);
        rreg(8'h00, v);
        chk(v, 32'h1);
        @(posedge clk);
        rst_n <= 1'b0;
        #1 chk(32'({rdy, qn, q}), 32'h30);
        @(posedge clk);
        rst_n <= 1'b1;
        step(7'h70);
        chk(32'({qn, q}), 32'h11);
        rreg(8'h0C, v);
        chk(v, 32'h1);
        wreg(8'h0C, 32'h0);
        rreg(8'h0C, v);
        chk(v, 32'h0);
        rreg(8'h00, v);
        chk(v, 32'h0);
        end_sim();
    end
endmodule
`default_nettype wire
